/* include/gpt_pkg.sv */
// Package with register map, field positions and types of the timer/compare block.
package gpt_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_OFS [3] = '{16'h7404, 16'h7408, 16'h740C};
  localparam logic [15:0] PER_OFS [3] = '{16'h7410, 16'h7414, 16'h7418};
  localparam logic [15:0] CMP_OFS [3] = '{16'h741C, 16'h7420, 16'h7424};
  localparam logic [15:0] CNT_OFS [3] = '{16'h7428, 16'h742C, 16'h7430};
  localparam logic [15:0] FCMP_OFS [3] = '{16'h7434, 16'h7438, 16'h743C};
  localparam logic [15:0] FCTRL_OFS = 16'h7440;
  localparam logic [15:0] ACT_OFS = 16'h7444;
  localparam logic [15:0] OLC_OFS = 16'h7448;
  localparam logic [15:0] DB_OFS = 16'h744C;
  localparam logic [15:0] FLAG_OFS = 16'h7450;
  localparam logic [15:0] MASK_OFS = 16'h7454;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_CMPEN_BIT = 1;
  localparam int CTRL_POL_LSB = 2;
  localparam int CTRL_EN_BIT = 6;
  localparam int CTRL_CASC_BIT = 7;
  localparam int CTRL_PSC_LSB = 8;
  localparam int CTRL_MODE_LSB = 11;
  localparam int FCTRL_CMPMODE_BIT = 0;
  localparam int FCTRL_EN_BIT = 15;
  localparam int FLAG_PER = 0;
  localparam int FLAG_UF = 1;
  localparam int FLAG_OF = 2;
  localparam int FLAG_CMP = 3;
  localparam int FLAG_FC_LSB = 12;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [11:0] DB_RST = 12'h000;
  localparam logic [11:0] DB_MAX_CYC = 12'h800;
  localparam logic [14:0] FLAG_RST = 15'h0000;
  // ----------------------------------------------------------------
  // Codes and types
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_HOLD = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] POL_FORCE_LOW = 2'h0;
  localparam logic [1:0] POL_ACT_LOW = 2'h1;
  localparam logic [1:0] POL_ACT_HIGH = 2'h2;
  localparam logic [1:0] POL_FORCE_HIGH = 2'h3;
  typedef enum logic [2:0] {
    MODE_STOP, MODE_SINGLE_UP, MODE_CONT_UP, MODE_DIR_UPDN, MODE_CONT_UPDN
  } tmode_t;
  typedef struct packed {
    logic [31:0] cnt;
    logic up;
    logic per;
    logic uf;
    logic of;
    logic stop;
  } step_t;
endpackage

/* include/db_if.sv */
// Interface joining the main block to one dead-band generator.
`timescale 1ns/1ps
interface db_if;
  logic raw;
  logic [11:0] dly;
  logic hi;
  logic lo;
  modport unit (input raw, input dly, output hi, output lo);
  modport user (output raw, output dly, input hi, input lo);
endinterface

/* rtl/sync3.sv */
// Three-stage input synchroniser that accepts a level once stages two and three agree.
`timescale 1ns/1ps
module sync3 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic s1_q, s2_q, s3_q;

  // The first stage is only read by the second, so metastability stays contained.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) q <= s3_q;
    end
  end
endmodule // sync3

/* rtl/deadband_unit.sv */
// Dead-band generator turning one PWM level into a complementary pair with a gap.
`timescale 1ns/1ps
module deadband_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  db_if.unit p
);
  logic last_q, hi_q, lo_q;
  logic [11:0] cnt_q;

  // On each edge of the raw level the new side turns on after dly cycles, with both outputs off in between.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 1'b0;
      hi_q <= 1'b0;
      lo_q <= 1'b1;
      cnt_q <= 12'h000;
    end else if (ce) begin
      if (p.raw != last_q) begin
        last_q <= p.raw;
        hi_q <= (p.dly == 12'h000) & p.raw;
        lo_q <= (p.dly == 12'h000) & ~p.raw;
        cnt_q <= p.dly;
      end else if (cnt_q != 12'h000) begin
        cnt_q <= cnt_q - 12'h001;
        if (cnt_q == 12'h001) begin
          hi_q <= last_q;
          lo_q <= ~last_q;
        end
      end
    end
  end

  assign p.hi = hi_q;
  assign p.lo = lo_q;
endmodule // deadband_unit

/* rtl/gp_timer_compare_pwm.sv */
// Three general-purpose timers with compare/PWM pins and three full compare units.
//
// Overview of operation
// - Cascade: timer 2 flags on 32-bit events.
// - Cascade: each half keeps its compare flag.
// - Single-up: after period, zero and disable.
// - Timer 2 directional mode rolls over freely.
// - Compare off: pin floats, no match events.
// - Compare zero: output high whole period.
// - Full compare off: all its pins float.
// - Full compare matches timer 1, toggles, flags.
// - Each output has its own match action.
// - Actions: 10 high, 01 low, 11 invert.
// - Full compare timing equals timer compare in compare mode; PWM mode adds a dead-band cycle.
// - Compare outputs pass the output logic stage.
// - Dead-band of 0 to 2048 cycles.
// - Dead-band adjusts in single-cycle steps.
// - Writing one clears a flag; zero keeps.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
module gp_timer_compare_pwm (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [15:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic TDIR,
  output logic [2:0] T_PWM,
  output logic [2:0] T_PWM_OE,
  output logic [5:0] FC_PWM,
  output logic [5:0] FC_PWM_OE,
  output logic IRQ
);
  import gpt_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] ctrl_q [3];
  logic [15:0] per_q [3];
  logic [15:0] cmpv_q [3];
  logic [15:0] cnt_q [3];
  logic [15:0] fcmp_q [3];
  logic [6:0] psc_q [3];
  logic [2:0] up_q, pwm_q, mc_q, fpwm_q, fmc_q;
  logic [15:0] fctrl_q;
  logic [11:0] act_q, olc_q, db_q;
  logic [14:0] flag_q, mask_q;
  logic [5:0] fout_q;
  logic ack_q, irq_q;
  logic [31:0] rdata_q;
  logic [2:0] tout_q, toe_q;
  logic [5:0] fpin_q, foe_q;
  logic dir_s;

  // Combinational view.
  logic [15:0] ectl [3];
  tmode_t mode_e [3];
  logic [6:0] lim [3];
  logic [2:0] run, tick, perv, ufv, ofv, stopv, startv, upn, cm;
  logic [15:0] cnt_n [3];
  logic [2:0] fm;
  logic [14:0] set_v;
  logic [2:0] db_hi, db_lo;
  logic casc, fen, fcmode;
  logic req, wr_go, rd_go;
  logic [31:0] rdata_d;
  step_t s16 [3];
  step_t s32;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // One count step; mx gives the width, roll lets the count run past period and zero.
  function automatic step_t step(input logic [31:0] c, input logic [31:0] p,
                                 input logic [31:0] mx, input tmode_t m,
                                 input logic dpin, input logic up, input logic roll);
    step_t s;
    logic [31:0] inc;
    logic [31:0] dec;
    inc = (c + 32'h0000_0001) & mx;
    dec = (c - 32'h0000_0001) & mx;
    s = '{cnt: c, up: up, per: 1'b0, uf: 1'b0, of: 1'b0, stop: 1'b0};
    unique case (m)
      MODE_STOP: s.cnt = c;
      MODE_SINGLE_UP: begin
        if (c == p) begin
          s.cnt = 32'h0000_0000;
          s.stop = 1'b1;
        end else begin
          s.cnt = inc;
        end
      end
      MODE_CONT_UP: s.cnt = (c == p) ? 32'h0000_0000 : inc;
      MODE_DIR_UPDN: begin
        s.up = dpin;
        if (dpin) begin
          s.cnt = (c == p && !roll) ? 32'h0000_0000 : inc;
        end else begin
          s.cnt = (c == 32'h0000_0000 && !roll) ? p : dec;
        end
      end
      MODE_CONT_UPDN: begin
        // The count turns at period, so one PWM cycle spans twice the period value.
        if (up) begin
          if (c >= p) begin
            s.up = 1'b0;
            s.cnt = dec;
          end else begin
            s.cnt = inc;
          end
        end else if (c == 32'h0000_0000) begin
          s.up = 1'b1;
          s.cnt = inc;
        end else begin
          s.cnt = dec;
        end
      end
      default: s.cnt = c;
    endcase
    s.per = (s.cnt == p) && (s.cnt != c);
    s.uf = (s.cnt == 32'h0000_0000) && (c != 32'h0000_0000);
    s.of = (c == mx) && (s.cnt != c);
    return s;
  endfunction

  // Merge bus write data into a 16-bit register under the two low byte enables.
  function automatic logic [15:0] wr16(input logic [15:0] o, input logic [31:0] d,
                                       input logic [3:0] be);
    wr16 = {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
  endfunction

  // Output logic stage: force or set the polarity of a raw level.
  function automatic logic olc(input logic [1:0] pol, input logic x);
    unique case (pol)
      POL_FORCE_LOW: olc = 1'b0;
      POL_ACT_LOW: olc = ~x;
      POL_ACT_HIGH: olc = x;
      POL_FORCE_HIGH: olc = 1'b1;
    endcase
  endfunction

  // Compare-mode action applied to one output at a match.
  function automatic logic act(input logic [1:0] a, input logic o);
    unique case (a)
      ACT_HOLD: act = o;
      ACT_LOW: act = 1'b0;
      ACT_HIGH: act = 1'b1;
      ACT_TOGGLE: act = ~o;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // One wait state on every access; the read word is sampled in the wait cycle.
  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign wr_go = AVS_WRITE & ack_q;
  assign rd_go = AVS_READ & ack_q;
  assign AVS_READDATA = rdata_q;

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    for (int i = 0; i < 3; i++) begin
      if (AVS_ADDRESS == CTRL_OFS[i]) rdata_d[15:0] = ctrl_q[i];
      if (AVS_ADDRESS == PER_OFS[i]) rdata_d[15:0] = per_q[i];
      if (AVS_ADDRESS == CMP_OFS[i]) rdata_d[15:0] = cmpv_q[i];
      if (AVS_ADDRESS == CNT_OFS[i]) rdata_d[15:0] = cnt_q[i];
      if (AVS_ADDRESS == FCMP_OFS[i]) rdata_d[15:0] = fcmp_q[i];
    end
    if (AVS_ADDRESS == FCTRL_OFS) rdata_d[15:0] = fctrl_q;
    if (AVS_ADDRESS == ACT_OFS) rdata_d[11:0] = act_q;
    if (AVS_ADDRESS == OLC_OFS) rdata_d[11:0] = olc_q;
    if (AVS_ADDRESS == DB_OFS) rdata_d[11:0] = db_q;
    if (AVS_ADDRESS == FLAG_OFS) rdata_d[14:0] = flag_q;
    if (AVS_ADDRESS == MASK_OFS) rdata_d[14:0] = mask_q;
  end

  // Handshake and read data register.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (CE) begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q) rdata_q <= rdata_d;
    end
  end

  // Software-only configuration registers; dead-band saturates at its maximum.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 3; i++) begin
        per_q[i] <= REG_RST;
        cmpv_q[i] <= REG_RST;
        fcmp_q[i] <= REG_RST;
      end
      fctrl_q <= REG_RST;
      act_q <= REG_RST[11:0];
      olc_q <= REG_RST[11:0];
      db_q <= DB_RST;
      mask_q <= FLAG_RST;
    end else if (CE && wr_go) begin
      for (int i = 0; i < 3; i++) begin
        if (AVS_ADDRESS == PER_OFS[i]) per_q[i] <= wr16(per_q[i], AVS_WRITEDATA, AVS_BYTEENABLE);
        if (AVS_ADDRESS == CMP_OFS[i]) cmpv_q[i] <= wr16(cmpv_q[i], AVS_WRITEDATA, AVS_BYTEENABLE);
        if (AVS_ADDRESS == FCMP_OFS[i]) fcmp_q[i] <= wr16(fcmp_q[i], AVS_WRITEDATA, AVS_BYTEENABLE);
      end
      if (AVS_ADDRESS == FCTRL_OFS) fctrl_q <= wr16(fctrl_q, AVS_WRITEDATA, AVS_BYTEENABLE);
      if (AVS_ADDRESS == ACT_OFS) act_q <= AVS_WRITEDATA[11:0];
      if (AVS_ADDRESS == OLC_OFS) olc_q <= AVS_WRITEDATA[11:0];
      if (AVS_ADDRESS == DB_OFS) begin
        db_q <= (AVS_WRITEDATA[11:0] > DB_MAX_CYC) ? DB_MAX_CYC : AVS_WRITEDATA[11:0];
      end
      if (AVS_ADDRESS == MASK_OFS) mask_q <= AVS_WRITEDATA[14:0];
    end
  end

  // ----------------------------------------------------------------
  // Timer stepping
  // ----------------------------------------------------------------
  sync3 u_dir (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .d(TDIR),
    .q(dir_s)
  );

  assign casc = ctrl_q[1][CTRL_CASC_BIT];
  assign fen = fctrl_q[FCTRL_EN_BIT];
  assign fcmode = fctrl_q[FCTRL_CMPMODE_BIT];

  // While cascaded, timer 3 runs on timer 2's control and clock as the high half.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ectl[i] = (i == 2 && casc) ? ctrl_q[1] : ctrl_q[i];
      mode_e[i] = tmode_t'(ectl[i][CTRL_MODE_LSB +: 3]);
      run[i] = ectl[i][CTRL_EN_BIT] && (mode_e[i] != MODE_STOP);
      lim[i] = 7'((8'h01 << ectl[i][CTRL_PSC_LSB +: 3]) - 8'h01);
      tick[i] = run[i] && (psc_q[i] == lim[i]);
      s16[i] = step({16'h0000, cnt_q[i]}, {16'h0000, per_q[i]}, 32'h0000_FFFF,
                    mode_e[i], dir_s, up_q[i], i == 1);
      cnt_n[i] = s16[i].cnt[15:0];
      upn[i] = s16[i].up;
      perv[i] = tick[i] & s16[i].per;
      ufv[i] = tick[i] & s16[i].uf;
      ofv[i] = tick[i] & s16[i].of;
      stopv[i] = tick[i] & s16[i].stop;
      startv[i] = ufv[i];
    end
    s32 = step({cnt_q[2], cnt_q[1]}, {per_q[2], per_q[1]}, 32'hFFFF_FFFF,
               mode_e[1], dir_s, up_q[1], 1'b1);
    if (casc) begin
      tick[2] = tick[1];
      cnt_n[1] = s32.cnt[15:0];
      cnt_n[2] = s32.cnt[31:16];
      upn[1] = s32.up;
      upn[2] = s32.up;
      perv[1] = tick[1] & s32.per;
      ufv[1] = tick[1] & s32.uf;
      ofv[1] = tick[1] & s32.of;
      stopv[1] = tick[1] & s32.stop;
      startv[1] = ufv[1];
      startv[2] = ufv[1];
      perv[2] = 1'b0;
      ufv[2] = 1'b0;
      ofv[2] = 1'b0;
      stopv[2] = 1'b0;
    end
    for (int i = 0; i < 3; i++) begin
      // Each half compares against its own register, also when cascaded.
      cm[i] = tick[i] && ctrl_q[i][CTRL_CMPEN_BIT] && (cnt_n[i] == cmpv_q[i]);
      fm[i] = tick[0] && fen && (cnt_n[0] == fcmp_q[i]);
      set_v[4 * i + FLAG_PER] = perv[i];
      set_v[4 * i + FLAG_UF] = ufv[i];
      set_v[4 * i + FLAG_OF] = ofv[i];
      set_v[4 * i + FLAG_CMP] = cm[i];
      set_v[FLAG_FC_LSB + i] = fm[i];
    end
  end

  // Counters, prescalers and count direction; a counter write beats a count step.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= REG_RST;
        psc_q[i] <= 7'h00;
      end
      up_q <= 3'h7;
    end else if (CE) begin
      for (int i = 0; i < 3; i++) begin
        if (wr_go && AVS_ADDRESS == CNT_OFS[i]) begin
          cnt_q[i] <= wr16(cnt_q[i], AVS_WRITEDATA, AVS_BYTEENABLE);
        end else if (tick[i]) begin
          cnt_q[i] <= cnt_n[i];
          up_q[i] <= upn[i];
        end
        if (!run[i] || psc_q[i] == lim[i]) psc_q[i] <= 7'h00;
        else psc_q[i] <= psc_q[i] + 7'h01;
      end
    end
  end

  // Control registers; hardware drops the enable bit when a single-up run ends.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 3; i++) ctrl_q[i] <= REG_RST;
    end else if (CE) begin
      for (int i = 0; i < 3; i++) begin
        if (wr_go && AVS_ADDRESS == CTRL_OFS[i]) begin
          ctrl_q[i] <= wr16(ctrl_q[i], AVS_WRITEDATA, AVS_BYTEENABLE);
        end else if (stopv[i]) begin
          ctrl_q[i][CTRL_EN_BIT] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Waveforms
  // ----------------------------------------------------------------
  // First match of a period raises the level, the second drops it; a match on the
  // period start wins, so a zero compare value keeps the level high all period.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwm_q <= 3'h0;
      mc_q <= 3'h0;
      fpwm_q <= 3'h0;
      fmc_q <= 3'h0;
    end else if (CE) begin
      for (int i = 0; i < 3; i++) begin
        if (cm[i] && (startv[i] || !mc_q[i])) begin
          pwm_q[i] <= 1'b1;
          mc_q[i] <= 1'b1;
        end else if (cm[i]) begin
          pwm_q[i] <= 1'b0;
        end else if (startv[i]) begin
          pwm_q[i] <= 1'b0;
          mc_q[i] <= 1'b0;
        end
        if (fm[i] && !fcmode && (startv[0] || !fmc_q[i])) begin
          fpwm_q[i] <= 1'b1;
          fmc_q[i] <= 1'b1;
        end else if (fm[i] && !fcmode) begin
          fpwm_q[i] <= 1'b0;
        end else if (startv[0]) begin
          fpwm_q[i] <= 1'b0;
          fmc_q[i] <= 1'b0;
        end
      end
    end
  end

  // Compare mode: each of the two outputs of a unit takes its own action code.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fout_q <= 6'h00;
    end else if (CE) begin
      for (int n = 0; n < 6; n++) begin
        if (fcmode && fm[n / 2]) fout_q[n] <= act(act_q[2 * n +: 2], fout_q[n]);
      end
    end
  end

  // Dead-band pairs, fed from the PWM-mode level of each full compare unit.
  db_if dbs [3] ();
  for (genvar g = 0; g < 3; g++) begin : g_db
    assign dbs[g].raw = fpwm_q[g];
    assign dbs[g].dly = db_q;
    deadband_unit u_db (
      .clk(CLK),
      .rst_n(RST_N),
      .ce(CE),
      .p(dbs[g])
    );
    assign db_hi[g] = dbs[g].hi;
    assign db_lo[g] = dbs[g].lo;
  end

  // Pin registers; enables float the pins while the compare function is off.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tout_q <= 3'h0;
      toe_q <= 3'h0;
      fpin_q <= 6'h00;
      foe_q <= 6'h00;
    end else if (CE) begin
      for (int i = 0; i < 3; i++) begin
        tout_q[i] <= olc(ctrl_q[i][CTRL_POL_LSB +: 2], pwm_q[i]);
        toe_q[i] <= ctrl_q[i][CTRL_CMPEN_BIT];
      end
      for (int n = 0; n < 6; n++) begin
        if (fcmode) fpin_q[n] <= olc(olc_q[2 * n +: 2], fout_q[n]);
        else fpin_q[n] <= olc(olc_q[2 * n +: 2], n[0] ? db_lo[n / 2] : db_hi[n / 2]);
        foe_q[n] <= fen;
      end
    end
  end

  assign T_PWM = tout_q;
  assign T_PWM_OE = toe_q;
  assign FC_PWM = fpin_q;
  assign FC_PWM_OE = foe_q;

  // ----------------------------------------------------------------
  // Flags and interrupt
  // ----------------------------------------------------------------
  // A read clears only the bits it returned, so a flag set meanwhile is not lost;
  // a new event always beats a clear in the same cycle.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_q <= FLAG_RST;
      irq_q <= 1'b0;
    end else if (CE) begin
      flag_q <= (flag_q
                 & ~((rd_go && AVS_ADDRESS == FLAG_OFS) ? rdata_q[14:0] : 15'h0000)
                 & ~((wr_go && AVS_ADDRESS == FLAG_OFS) ? AVS_WRITEDATA[14:0] : 15'h0000))
                | set_v;
      irq_q <= |(flag_q & mask_q);
    end
  end

  assign IRQ = irq_q;
endmodule // gp_timer_compare_pwm

/* sim/gp_timer_compare_pwm_asserts.sv */
// Port-level checker for the timer/compare block, bound to its top module.
`timescale 1ns/1ps
module gpt_port_checker (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [2:0] T_PWM_OE,
  input wire logic [5:0] FC_PWM_OE,
  input wire logic IRQ
);
  // --------------------------------------------------------------
  // Bus handshake, enables and interrupt line
  // --------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_wait_first: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
    else $error("request answered without its wait state");
  a_wait_single: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CE
    |=> !AVS_WAITREQUEST)
    else $error("wait state longer than one cycle");
  a_wait_idle: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
    else $error("waitrequest high with no request");
  // Read data may only move when a request was seen, so software never reads a torn value.
  a_rdata_hold: assert property (!(AVS_READ || AVS_WRITE) |=> $stable(AVS_READDATA))
    else $error("read data moved without a request");
  a_toe_by_write: assert property ($changed(T_PWM_OE) |-> $past(AVS_WRITE, 2))
    else $error("timer pin enable moved without a write");
  a_foe_by_write: assert property ($changed(FC_PWM_OE) |-> $past(AVS_WRITE, 2))
    else $error("full compare enable moved without a write");
  a_foe_all_alike: assert property (FC_PWM_OE == 6'h00 || FC_PWM_OE == 6'h3F)
    else $error("full compare pins not released together");
  a_irq_bus_clear: assert property ($fell(IRQ) |-> $past(AVS_READ || AVS_WRITE, 2))
    else $error("interrupt dropped without a bus access");
endmodule // gpt_port_checker

bind gp_timer_compare_pwm gpt_port_checker chk_u (.CLK, .RST_N, .CE, .AVS_READ, .AVS_WRITE,
  .AVS_READDATA, .AVS_WAITREQUEST, .T_PWM_OE, .FC_PWM_OE, .IRQ);

/* sim/power_stage_model.sv */
// Behavioural power stage seen by the gate pins of the block.
`timescale 1ns/1ps
module power_stage_model (
  input wire logic [2:0] t_pwm,
  input wire logic [2:0] t_oe,
  input wire logic [5:0] fc_pwm,
  input wire logic [5:0] fc_oe,
  output logic [2:0] t_gate,
  output logic [5:0] fc_gate
);
  // A released pin is pulled low at the gate, so a floating output switches nothing.
  assign t_gate = t_pwm & t_oe;
  assign fc_gate = fc_pwm & fc_oe;
endmodule // power_stage_model

/* sim/gp_timer_compare_pwm_tb.sv */
// Self-checking bench for the timer/compare block.
`timescale 1ns/1ps
module gp_timer_compare_pwm_tb;
  import gpt_pkg::*;
  // --------------------------------------------------------------
  // Signals, clock and instances
  // --------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, got;
  logic wait_req, irq, b;
  logic tdir = 1'b1;
  logic [2:0] t_pwm, t_oe, t_gate;
  logic [5:0] fc_pwm, fc_oe, fc_gate;
  int mismatches = 0;
  int comparisons = 0;

  // Free-running 25 MHz clock.
  initial begin
    forever #20 clk = ~clk;
  end

  gp_timer_compare_pwm dut_u (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .AVS_ADDRESS(addr),
    .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .TDIR(tdir), .T_PWM(t_pwm),
    .T_PWM_OE(t_oe), .FC_PWM(fc_pwm), .FC_PWM_OE(fc_oe), .IRQ(irq));
  power_stage_model stage_u (.t_pwm(t_pwm), .t_oe(t_oe), .fc_pwm(fc_pwm), .fc_oe(fc_oe),
    .t_gate(t_gate), .fc_gate(fc_gate));

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One bus cycle; the request is held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    rd_en <= ~w;
    wr_en <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    got = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  // Counts the cycles in which both gates of unit 1 are off after a swap.
  task automatic gap(input int n);
    int k;
    k = 0;
    bus(1'b1, DB_OFS, 32'(n));
    repeat (130) @(posedge clk);
    while (fc_gate[1:0] !== 2'b00 && k < 200) begin
      @(posedge clk);
      k++;
    end
    k = 0;
    while (fc_gate[1:0] === 2'b00 && k < 200) begin
      @(posedge clk);
      k++;
    end
    chk(k, n);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A hang costs a mismatch; the whole run needs well under a tenth of this.
  initial begin
    #2000000;
    mismatches++;
    end_of_test();
  end

  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, CTRL_OFS[0], 32'h0);
    chk(got, 32'h0);
    bus(1'b1, 16'h7500, 32'h0000FFFF);
    bus(1'b0, 16'h7500, 32'h0);
    chk(got, 32'h0);
    bus(1'b1, DB_OFS, 32'h00000FFF);
    bus(1'b0, DB_OFS, 32'h0);
    chk(got, 32'h00000800);
    // Single-up run of timer 1 with its period flag unmasked.
    bus(1'b1, MASK_OFS, 32'h1);
    bus(1'b1, PER_OFS[0], 32'h5);
    bus(1'b1, CTRL_OFS[0], 32'h0840);
    repeat (12) @(posedge clk);
    bus(1'b0, CNT_OFS[0], 32'h0);
    chk(got, 32'h0);
    bus(1'b0, CTRL_OFS[0], 32'h0);
    chk(got, 32'h0800);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, FLAG_OFS, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, FLAG_OFS, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, CTRL_OFS[0], 32'h0840);
    repeat (12) @(posedge clk);
    bus(1'b0, FLAG_OFS, 32'h0);
    chk(got & 32'h1, 32'h1);
    bus(1'b0, FLAG_OFS, 32'h0);
    chk(got & 32'h1, 32'h0);
    // Continuous up with compare value zero, then compare switched off.
    bus(1'b1, MASK_OFS, 32'h0);
    bus(1'b1, PER_OFS[0], 32'h4);
    bus(1'b1, CTRL_OFS[0], 32'h104A);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      chk({29'h0, t_oe[0], t_gate[0], t_pwm[0]}, 32'h7);
    end
    bus(1'b1, CTRL_OFS[0], 32'h1048);
    bus(1'b0, FLAG_OFS, 32'h0);
    repeat (10) @(posedge clk);
    bus(1'b0, FLAG_OFS, 32'h0);
    chk({29'h0, got[3], t_oe[0], t_gate[0]}, 32'h0);
    // Timers 2 and 3 cascaded, counting 0x0001_0000 up to the period 0x0001_0004.
    bus(1'b1, CTRL_OFS[0], 32'h0);
    bus(1'b1, PER_OFS[1], 32'h4);
    bus(1'b1, PER_OFS[2], 32'h1);
    bus(1'b1, CNT_OFS[2], 32'h1);
    bus(1'b1, CMP_OFS[1], 32'h2);
    bus(1'b1, CMP_OFS[2], 32'h1);
    bus(1'b1, CTRL_OFS[2], 32'h0002);
    bus(1'b0, FLAG_OFS, 32'h0);
    bus(1'b1, CTRL_OFS[1], 32'h10C2);
    repeat (8) @(posedge clk);
    bus(1'b1, CTRL_OFS[1], 32'h0);
    bus(1'b0, FLAG_OFS, 32'h0);
    chk(got & 32'h0990, 32'h0890);
    // Timer 2 directional mode runs past a period of 3 both ways.
    bus(1'b1, PER_OFS[1], 32'h3);
    bus(1'b1, CNT_OFS[1], 32'h0);
    bus(1'b1, CTRL_OFS[1], 32'h1840);
    repeat (10) @(posedge clk);
    bus(1'b0, CNT_OFS[1], 32'h0);
    chk({31'h0, got[15:0] > 16'h0004}, 32'h1);
    tdir <= 1'b0;
    repeat (40) @(posedge clk);
    bus(1'b0, CNT_OFS[1], 32'h0);
    chk({31'h0, got[15:0] > 16'h0003}, 32'h1);
    bus(1'b1, CTRL_OFS[1], 32'h0);
    // Full compare units in compare mode against timer 1 counting 0 to 7.
    bus(1'b1, OLC_OFS, 32'h0AAA);
    bus(1'b1, ACT_OFS, 32'h0036);
    bus(1'b1, FCMP_OFS[0], 32'h3);
    bus(1'b1, FCMP_OFS[1], 32'h3);
    bus(1'b1, FCTRL_OFS, 32'h8001);
    bus(1'b1, PER_OFS[0], 32'h7);
    bus(1'b1, CTRL_OFS[0], 32'h1040);
    repeat (20) @(posedge clk);
    b = fc_gate[2];
    chk({26'h0, fc_oe}, 32'h3F);
    chk({30'h0, fc_gate[1:0]}, 32'h1);
    repeat (8) @(posedge clk);
    chk({31'h0, fc_gate[2]}, {31'h0, ~b});
    bus(1'b0, FLAG_OFS, 32'h0);
    chk(got & 32'h3000, 32'h3000);
    bus(1'b1, OLC_OFS, 32'h0AAE);
    repeat (3) @(posedge clk);
    chk({31'h0, fc_gate[1]}, 32'h1);
    bus(1'b1, FCTRL_OFS, 32'h0);
    repeat (2) @(posedge clk);
    chk({26'h0, fc_oe}, 32'h0);
    // PWM mode through the dead-band, timer 1 continuous up/down.
    bus(1'b1, OLC_OFS, 32'h0AAA);
    bus(1'b1, FCMP_OFS[0], 32'h8);
    bus(1'b1, PER_OFS[0], 32'h1F);
    bus(1'b1, CTRL_OFS[0], 32'h2040);
    bus(1'b1, FCTRL_OFS, 32'h8000);
    gap(4);
    gap(5);
    end_of_test();
  end
endmodule // gp_timer_compare_pwm_tb
